// *** acrs_ctrl.sv ***
// converter control: input select, reference select, result formatting, sensor calibration
`timescale 1ns/1ps
`include "acrs_defs.svh"
module acrs_ctrl #(
	parameter logic [7:0] SENSOR_GAIN_CAL = 8'h80, // arbitrary default, factory sets it
	parameter logic [7:0] SENSOR_OFFSET_CAL = 8'h00 // arbitrary default, factory sets it
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire acrs_pkg::acrs_bus_t bus,
	output logic [7:0] rdata,
	input wire logic conv_start,
	input wire acrs_pkg::acrs_sample_t sample,
	input wire logic flag_clear,
	output logic conversion_complete_flag,
	output acrs_pkg::acrs_analog_t analog
);
	import acrs_pkg::*;

	acrs_state_t s_reg;
	acrs_state_t s_next;
	logic [9:0] coded;
	logic [5:0] req_chan;
	logic [2:0] req_ref;
	logic [7:0] high_byte;
	logic [7:0] low_byte;
	logic paired;
	logic left_adjust_result;

	assign req_chan = {s_reg.ctb_reg[3], s_reg.sel_reg[4:0]};
	assign req_ref = {s_reg.ctb_reg[4], s_reg.sel_reg[7:6]};
	assign left_adjust_result = s_reg.sel_reg[5];

	// format the raw sample by conversion kind
	always_comb begin
		coded = sample.mag;
		unique case (analog.kind)
			ACRS_KIND_UNI: begin
				coded = sample.neg ? 10'h000 : sample.mag;
			end
			ACRS_KIND_BIP: begin
				// sign into the top bit, two's complement
				if (sample.neg) begin
					coded = (sample.mag > 10'd512) ? `ACRS_BIP_MIN : 10'((~sample.mag) + 10'd1);
				end else begin
					coded = (sample.mag > 10'd511) ? `ACRS_BIP_MAX : sample.mag;
				end
			end
			default: begin
				coded = sample.mag;
			end
		endcase
	end

	// alignment applies live from the select register
	always_comb begin
		if (left_adjust_result) begin
			high_byte = s_reg.result[9:2];
			low_byte = {s_reg.result[1:0], 6'h00};
		end else begin
			high_byte = {6'h00, s_reg.result[9:8]};
			low_byte = s_reg.result[7:0];
		end
	end

	// decode active channel into kind and gain
	always_comb begin
		paired = s_reg.act_chan[5];
		analog.channel = s_reg.act_chan;
		analog.kind = ACRS_KIND_SINGLE;
		analog.gain = ACRS_GAIN_1X;
		if (s_reg.act_chan > `ACRS_CODE_SE_LAST && s_reg.act_chan < `ACRS_CODE_BANDGAP) begin
			analog.kind = s_reg.act_bip ? ACRS_KIND_BIP : ACRS_KIND_UNI;
			// codes 0x0C, 0x0F, 0x10, 0x13, 0x15, 0x18, 0x1A, 0x1D are 1x, the rest 20x
			if (s_reg.act_chan == 6'h0C || s_reg.act_chan == 6'h0F || s_reg.act_chan == 6'h10 ||
				s_reg.act_chan == 6'h13 || s_reg.act_chan == 6'h15 || s_reg.act_chan == 6'h18 ||
				s_reg.act_chan == 6'h1A || s_reg.act_chan == 6'h1D) begin
				analog.gain = ACRS_GAIN_1X;
			end else begin
				analog.gain = ACRS_GAIN_20X;
			end
		end else if (paired && s_reg.act_chan != `ACRS_CODE_TEMP) begin
			analog.kind = s_reg.act_bip ? ACRS_KIND_BIP : ACRS_KIND_UNI;
			// boost swaps 20x to 32x and 1x to 8x
			if (s_reg.act_chan[0] && s_reg.act_chan < 6'h3A) begin
				analog.gain = s_reg.act_boost ? ACRS_GAIN_8X : ACRS_GAIN_1X;
			end else begin
				analog.gain = s_reg.act_boost ? ACRS_GAIN_32X : ACRS_GAIN_20X;
			end
		end
		// reference decode, reserved code held safe
		// one process fills the whole analog struct, so it has a single driver
		analog.ref_pin_drive = 1'b0;
		unique case (s_reg.act_ref[1:0])
			2'b00: analog.reference = ACRS_REF_SUPPLY;
			2'b01: analog.reference = ACRS_REF_EXT;
			2'b10: analog.reference = s_reg.act_ref[2] ? ACRS_REF_2V56 : ACRS_REF_1V1;
			2'b11: begin
				analog.reference = s_reg.act_ref[2] ? ACRS_REF_2V56_BYP : ACRS_REF_SAFE;
				analog.ref_pin_drive = s_reg.act_ref[2];
			end
		endcase
		analog.long_conv = s_reg.ref_changed;
		analog.conv_cycles = s_reg.ref_changed ? `ACRS_INIT_CYCLES : `ACRS_NORM_CYCLES;
	end

	// next state: register writes, staging of selections, result capture
	always_comb begin
		s_next = s_reg;
		s_next.rdata = 8'h00;
		if (bus.wr) begin
			unique case (bus.addr)
				`ACRS_OFF_SELECT: s_next.sel_reg = bus.wdata;
				`ACRS_OFF_CTRL_B: s_next.ctb_reg = bus.wdata & 8'hDF;
				default: s_next.sel_reg = s_reg.sel_reg;
			endcase
		end
		if (s_reg.phase == ACRS_IDLE) begin
			// selections track writes only while idle
			if (req_ref != s_reg.act_ref) begin
				s_next.ref_changed = 1'b1;
			end
			s_next.act_chan = req_chan;
			s_next.act_ref = req_ref;
			s_next.act_bip = s_reg.ctb_reg[7];
			s_next.act_boost = s_reg.ctb_reg[6];
			if (conv_start) begin
				s_next.phase = ACRS_BUSY;
			end
		end else if (sample.done) begin
			s_next.phase = ACRS_IDLE;
			s_next.ref_changed = 1'b0;
			// result frozen while low byte read pending
			if (!s_reg.res_lock) begin
				s_next.result = coded;
			end
		end
		if (flag_clear) begin
			s_next.flag = 1'b0;
		end
		if (s_reg.phase == ACRS_BUSY && sample.done) begin
			s_next.flag = 1'b1;
		end
		if (bus.rd) begin
			unique case (bus.addr)
				`ACRS_OFF_SELECT: s_next.rdata = s_reg.sel_reg;
				`ACRS_OFF_CTRL_B: s_next.rdata = s_reg.ctb_reg;
				`ACRS_OFF_RES_LOW: begin
					s_next.rdata = low_byte;
					s_next.res_lock = 1'b1;
				end
				`ACRS_OFF_RES_HIGH: begin
					s_next.rdata = high_byte;
					s_next.res_lock = 1'b0;
				end
				`ACRS_OFF_CAL_GAIN: s_next.rdata = SENSOR_GAIN_CAL;
				`ACRS_OFF_CAL_OFFSET: s_next.rdata = SENSOR_OFFSET_CAL;
				`ACRS_OFF_STATUS: s_next.rdata = {6'h00, s_reg.phase == ACRS_BUSY, s_reg.flag};
				default: s_next.rdata = 8'h00;
			endcase
		end
	end

	// state register
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rdata = s_reg.rdata;
	assign conversion_complete_flag = s_reg.flag;

	flag_sets_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(s_reg.phase == ACRS_BUSY && sample.done) |=> conversion_complete_flag)
		else $error("flag not set");

	flag_holds_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(conversion_complete_flag && !flag_clear) |=> conversion_complete_flag)
		else $error("flag dropped without clear");

	flag_clears_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(flag_clear && !(s_reg.phase == ACRS_BUSY && sample.done)) |=> !conversion_complete_flag)
		else $error("flag not cleared");

	result_loaded_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(s_reg.phase == ACRS_BUSY && sample.done && !s_reg.res_lock) |=> s_reg.result == $past(coded))
		else $error("result not loaded");

	chan_held_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(s_reg.phase == ACRS_BUSY && !sample.done) |=> $stable(s_reg.act_chan))
		else $error("channel moved");

	ref_held_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(s_reg.phase == ACRS_BUSY && !sample.done) |=> $stable(s_reg.act_ref))
		else $error("reference moved");

	chan_form_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(s_reg.phase == ACRS_IDLE) |=> s_reg.act_chan == $past(req_chan))
		else $error("channel code not formed");

	ref_form_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(s_reg.phase == ACRS_IDLE) |=> s_reg.act_ref == $past(req_ref))
		else $error("reference code not formed");

	res_frozen_a: assert property (@(posedge core_clk) disable iff (!rstn)
		s_reg.res_lock |=> $stable(s_reg.result))
		else $error("result changed while locked");

	lock_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(bus.rd && bus.addr == `ACRS_OFF_RES_LOW) |=> s_reg.res_lock)
		else $error("low read did not lock");

	ref_safe_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(s_reg.act_ref == 3'b011) |-> !analog.ref_pin_drive)
		else $error("reserved drives pin");

	ext_ref_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(s_reg.act_ref[1:0] == 2'b01) |-> (analog.reference == ACRS_REF_EXT && !analog.ref_pin_drive))
		else $error("external reference wrong");

	byp_drive_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(s_reg.act_ref == 3'b111) |-> analog.ref_pin_drive)
		else $error("bypass not driven");

	long_conv_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(s_reg.phase == ACRS_IDLE && req_ref != s_reg.act_ref) |=> analog.conv_cycles == `ACRS_INIT_CYCLES)
		else $error("no long conversion");

	short_conv_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(s_reg.phase == ACRS_BUSY && sample.done) |=> !analog.long_conv)
		else $error("long conversion kept");

	uni_sat_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(analog.kind == ACRS_KIND_UNI && sample.neg) |-> coded == 10'h000)
		else $error("no saturation");

	bip_range_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(analog.kind == ACRS_KIND_BIP && !sample.neg) |-> !coded[9])
		else $error("positive bipolar has sign");

	bip_sign_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(analog.kind == ACRS_KIND_BIP && sample.neg && sample.mag != 10'h000) |-> coded[9])
		else $error("sign bit wrong");

	left_adj_a: assert property (@(posedge core_clk) disable iff (!rstn)
		left_adjust_result |-> (high_byte == s_reg.result[9:2] && low_byte == {s_reg.result[1:0], 6'h00}))
		else $error("left adjust wrong");

	right_adj_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!left_adjust_result |-> (high_byte == {6'h00, s_reg.result[9:8]} && low_byte == s_reg.result[7:0]))
		else $error("right adjust wrong");

	boost_gain_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(analog.gain == ACRS_GAIN_32X || analog.gain == ACRS_GAIN_8X) |-> (s_reg.act_boost && s_reg.act_chan[5]))
		else $error("boosted gain without boost");

	single_map_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(s_reg.act_chan <= `ACRS_CODE_SE_LAST || s_reg.act_chan == `ACRS_CODE_BANDGAP ||
		s_reg.act_chan == `ACRS_CODE_GROUND || s_reg.act_chan == `ACRS_CODE_TEMP) |-> analog.kind == ACRS_KIND_SINGLE)
		else $error("single-ended code not single");

	cal_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(bus.rd && bus.addr == `ACRS_OFF_CAL_GAIN) |=> rdata == SENSOR_GAIN_CAL)
		else $error("gain calibration wrong");
endmodule

// *** acrs_defs.svh ***
// offsets, channel codes, reset values, result limits and timing counts of the converter control block
`ifndef ACRS_DEFS_SVH
`define ACRS_DEFS_SVH
`define ACRS_OFF_CTRL_B 8'h03
`define ACRS_OFF_RES_HIGH 8'h05
`define ACRS_OFF_RES_LOW 8'h04
`define ACRS_OFF_SELECT 8'h07
`define ACRS_OFF_CAL_GAIN 8'h10
`define ACRS_OFF_CAL_OFFSET 8'h11
`define ACRS_OFF_STATUS 8'h12
`define ACRS_SEL_RESET 8'h00
`define ACRS_CTB_RESET 8'h00
`define ACRS_INIT_CYCLES 5'd25
`define ACRS_NORM_CYCLES 5'd13
`define ACRS_CODE_SE_LAST 6'h0A
`define ACRS_CODE_BANDGAP 6'h1E
`define ACRS_CODE_GROUND 6'h1F
`define ACRS_CODE_TEMP 6'h3F
`define ACRS_BIP_MIN 10'h200
`define ACRS_BIP_MAX 10'h1FF
`define ACRS_UNI_MAX 10'h3FF
`endif

// *** acrs_pkg.sv ***
// types shared by the converter control block
package acrs_pkg;
	typedef enum logic [2:0] {
		ACRS_REF_SUPPLY = 3'h0,
		ACRS_REF_EXT = 3'h1,
		ACRS_REF_1V1 = 3'h2,
		ACRS_REF_SAFE = 3'h3,
		ACRS_REF_2V56 = 3'h4,
		ACRS_REF_2V56_BYP = 3'h5
	} acrs_ref_t;
	typedef enum logic [1:0] {
		ACRS_GAIN_1X = 2'h0,
		ACRS_GAIN_8X = 2'h1,
		ACRS_GAIN_20X = 2'h2,
		ACRS_GAIN_32X = 2'h3
	} acrs_gain_t;
	typedef enum logic [1:0] {
		ACRS_KIND_SINGLE = 2'h0,
		ACRS_KIND_UNI = 2'h1,
		ACRS_KIND_BIP = 2'h2
	} acrs_kind_t;
	typedef enum logic [0:0] {
		ACRS_IDLE = 1'b0,
		ACRS_BUSY = 1'b1
	} acrs_phase_t;
	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} acrs_bus_t;
	// raw sample coming from the analog core
	typedef struct packed {
		logic done;
		logic [9:0] mag;
		logic neg;
	} acrs_sample_t;
	// analog settings handed to the converter core
	typedef struct packed {
		logic [5:0] channel;
		acrs_ref_t reference;
		logic ref_pin_drive;
		acrs_gain_t gain;
		acrs_kind_t kind;
		logic long_conv;
		logic [4:0] conv_cycles;
	} acrs_analog_t;
	typedef struct packed {
		logic [7:0] sel_reg;
		logic [7:0] ctb_reg;
		logic [5:0] act_chan;
		logic [2:0] act_ref;
		logic act_bip;
		logic act_boost;
		logic ref_changed;
		logic [9:0] result;
		logic res_lock;
		logic flag;
		acrs_phase_t phase;
		logic [7:0] rdata;
	} acrs_state_t;
endpackage

// *** acrs_ctrl_tb.sv ***
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "acrs_defs.svh"
module acrs_ctrl_tb;
	import acrs_pkg::*;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	acrs_bus_t bus = '0;
	logic [7:0] rdata;
	logic conv_start = 1'b0;
	acrs_sample_t sample = '0;
	logic flag_clear = 1'b0;
	logic conversion_complete_flag;
	acrs_analog_t analog;
	int failures = 0;
	int cmp_count = 0;
	int i;
	logic [15:0] lfsr = 16'h87FE;
	logic [7:0] sel_v;
	logic [7:0] ctb_v;
	logic [7:0] lo;
	logic [7:0] hi;
	logic [9:0] mag;
	logic [9:0] exp_r;
	logic [9:0] got;
	logic [5:0] gch [4] = '{6'h0B, 6'h0C, 6'h20, 6'h21};
	logic [1:0] gexp [8] = '{2'h2, 2'h2, 2'h0, 2'h0, 2'h2, 2'h3, 2'h0, 2'h1};
	logic [5:0] cch [8] = '{6'h05, 6'h3F, 6'h0B, 6'h0B, 6'h38, 6'h21, 6'h10, 6'h2C};
	logic [1:0] ckind [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2};
	logic [7:0] cbip = 8'hF0;
	logic [7:0] cneg = 8'h54;

	acrs_ctrl #(.SENSOR_GAIN_CAL(8'h9C), .SENSOR_OFFSET_CAL(8'hF5)) uut (
		.core_clk(core_clk),
		.rstn(rstn),
		.bus(bus),
		.rdata(rdata),
		.conv_start(conv_start),
		.sample(sample),
		.flag_clear(flag_clear),
		.conversion_complete_flag(conversion_complete_flag),
		.analog(analog)
	);

	// 125 MHz core clock
	always #4 core_clk = ~core_clk;

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// expected code; negative bipolar clamps at the bottom of the range
	function automatic logic [9:0] expect_res(input logic [1:0] k, input logic [9:0] m, input logic n);
		if (k == 2'h0) return m;
		if (k == 2'h1) return n ? 10'h000 : m;
		if (n) return (m >= 10'h200) ? `ACRS_BIP_MIN : (~m + 10'h001);
		return (m > `ACRS_BIP_MAX) ? `ACRS_BIP_MAX : m;
	endfunction

	function automatic acrs_ref_t exp_ref(input logic [2:0] c);
		case (c)
			3'h2: return ACRS_REF_1V1;
			3'h3: return ACRS_REF_SAFE;
			3'h6: return ACRS_REF_2V56;
			3'h7: return ACRS_REF_2V56_BYP;
			default: return c[0] ? ACRS_REF_EXT : ACRS_REF_SUPPLY;
		endcase
	endfunction

	task automatic chk(input logic [9:0] g, input logic [9:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge core_clk);
		bus.wr <= 1'b0;
	endtask

	// read data is only valid in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge core_clk);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic setup(input logic [7:0] s, input logic [7:0] c);
		sel_v = s;
		ctb_v = c;
		wr(`ACRS_OFF_SELECT, s);
		wr(`ACRS_OFF_CTRL_B, c);
		repeat (2) @(posedge core_clk);
		#1;
	endtask

	task automatic start;
		@(posedge core_clk);
		conv_start <= 1'b1;
		@(posedge core_clk);
		conv_start <= 1'b0;
	endtask

	task automatic finish(input logic [9:0] m, input logic n, input logic chkf);
		repeat (3) @(posedge core_clk);
		sample <= {1'b1, m, n};
		@(posedge core_clk);
		sample.done <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
		// flag stays up until it is cleared
		if (chkf) chk(conversion_complete_flag, 1'b1);
		@(posedge core_clk);
		flag_clear <= 1'b1;
		@(posedge core_clk);
		flag_clear <= 1'b0;
		#1;
		chk(conversion_complete_flag, 1'b0);
	endtask

	// low byte first, then high; rebuilds the code and checks padding
	task automatic read_res(output logic [9:0] r);
		rd(`ACRS_OFF_RES_LOW, lo);
		rd(`ACRS_OFF_RES_HIGH, hi);
		r = sel_v[5] ? {hi, lo[7:6]} : {hi[1:0], lo};
		chk(sel_v[5] ? lo[5:0] : hi[7:2], 6'h00);
	endtask

	initial begin
		#100000;
		failures++;
		stop_test;
	end

	initial begin
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
		rd(`ACRS_OFF_SELECT, lo);
		chk(lo, `ACRS_SEL_RESET);
		chk(conversion_complete_flag, 1'b0);
		wr(8'h20, 8'hFF);
		rd(8'h20, lo);
		chk(lo, 8'h00);
		rd(`ACRS_OFF_CAL_GAIN, lo);
		chk(lo, 8'h9C);
		rd(`ACRS_OFF_CAL_OFFSET, lo);
		chk(lo, 8'hF5);
		// reserved bit of control b reads zero
		wr(`ACRS_OFF_CTRL_B, 8'hFF);
		rd(`ACRS_OFF_CTRL_B, lo);
		chk(lo, 8'hDF);
		// every reference code, reserved one must not drive the pin
		for (i = 0; i < 8; i++) begin
			setup({i[1:0], 6'h00}, {3'h0, i[2], 4'h0});
			chk(analog.reference, exp_ref(i[2:0]));
			chk(analog.ref_pin_drive, i == 7);
		end
		chk(analog.conv_cycles, `ACRS_INIT_CYCLES);
		chk(analog.long_conv, 1'b1);
		// gain with and without boost, paired and unpaired codes
		for (i = 0; i < 8; i++) begin
			setup({3'h0, gch[i / 2][4:0]}, {1'b0, i[0], 2'h0, gch[i / 2][5], 3'h0});
			chk(analog.gain, gexp[i]);
		end
		// conversions of each kind, alignment alternating
		for (i = 0; i < 8; i++) begin
			lfsr = lfsr_next(lfsr);
			mag = (i > 5) ? 10'h3FF : lfsr[9:0];
			// temperature channel is measured against 1.1V
			setup({(i == 1) ? 2'b10 : 2'b00, i[0], cch[i][4:0]}, {cbip[i], 3'h0, cch[i][5], 3'h0});
			chk(analog.channel, cch[i]);
			chk(analog.kind, ckind[i]);
			exp_r = expect_res(ckind[i], mag, cneg[i]);
			start;
			finish(mag, cneg[i], 1'b1);
			read_res(got);
			chk(got, exp_r);
			if (cbip[i]) chk(got[9], cneg[i] & (|mag));
		end
		// alignment flips at once on the held result
		sel_v[5] = ~sel_v[5];
		wr(`ACRS_OFF_SELECT, sel_v);
		read_res(got);
		chk(got, exp_r);
		// channel and reference written mid-conversion wait for completion
		setup(8'h05, 8'h00);
		start;
		wr(`ACRS_OFF_SELECT, 8'h46);
		sel_v = 8'h46;
		repeat (2) @(posedge core_clk);
		#1;
		chk(analog.channel, 6'h05);
		chk(analog.reference, ACRS_REF_SUPPLY);
		// status shows busy, flag already cleared
		rd(`ACRS_OFF_STATUS, lo);
		chk(lo, 8'h02);
		lfsr = lfsr_next(lfsr);
		finish(lfsr[9:0], 1'b0, 1'b1);
		chk(analog.channel, 6'h06);
		chk(analog.reference, ACRS_REF_EXT);
		chk(analog.conv_cycles, `ACRS_INIT_CYCLES);
		chk(analog.long_conv, 1'b1);
		start;
		finish(lfsr[9:0], 1'b0, 1'b1);
		chk(analog.conv_cycles, `ACRS_NORM_CYCLES);
		chk(analog.long_conv, 1'b0);
		// low byte read holds the result against a newer conversion
		lfsr = lfsr_next(lfsr);
		start;
		finish(lfsr[9:0], 1'b0, 1'b1);
		rd(`ACRS_OFF_RES_LOW, lo);
		start;
		finish(~lfsr[9:0], 1'b0, 1'b0);
		rd(`ACRS_OFF_RES_HIGH, hi);
		chk({hi[1:0], lo}, lfsr[9:0]);
		stop_test;
	end
endmodule
